/* File: counter_cmd_pkg.sv */
// constants, types and timing figures shared by the card and reader ends
// assumes a single 25 MHz clock on both ends and byte-wide frame transfer
// Operation
// R01 - read request: 39h, counter 00h-02h, [CMAC], CRC
// R02 - read reply: 3 bytes, [CMAC], CRC, else NAK
// R03 - counter 2 protected: read only when authenticated
// R04 - increment request: A5h, counter, 4-byte argument, [CMAC], CRC
// R05 - counter 2 protected: increment only when authenticated
// R06 - increment uses low three argument bytes only
// R07 - argument bytes arrive least significant first
// R08 - all-ones is final; nonzero increments then refused
// R09 - overflowing increment answers NAK, counter kept
// R10 - increment by zero is legal, counter unchanged
// R11 - secure messaging: read request must carry CMAC
// R12 - secure messaging: increment request must carry CMAC
// R13 - secure messaging: increment acked by MAC, not ACK
// R14 - reply not before n=9; reader timeout 5 ms
// R15 - bad counter number, CRC or CMAC gives NAK
// R16 - protected counter 2 unauthenticated gives NAK, unchanged
package counter_cmd_pkg;

  localparam int CLK_PERIOD_NS = 40;

  // command codes and frame layout
  localparam logic [7:0] OP_READ = 8'h39;
  localparam logic [7:0] OP_INCR = 8'ha5;
  localparam logic [7:0] CNT_LAST = 8'h02;
  localparam logic [4:0] IDX_OP = 5'h00;
  localparam logic [4:0] IDX_CNT = 5'h01;
  localparam logic [4:0] IDX_ARG = 5'h02;
  localparam logic [4:0] IDX_ARG_TOP = 5'h05;
  localparam logic [4:0] LEN_READ = 5'h04;
  localparam logic [4:0] LEN_INCR = 5'h08;
  localparam logic [4:0] LEN_MAC = 5'h08;
  localparam logic [4:0] LEN_ARG = 5'h04;
  localparam logic [4:0] IDX_MAX = 5'h1f;

  // counter geometry
  localparam int CNT_NUM = 3;
  localparam int CNT_W = 24;
  localparam logic [23:0] CNT_RESET = 24'h00_0000;
  localparam logic [1:0] DATA_BYTES_LAST = 2'h2;

  // frame delay n=9 at the 13.56 MHz carrier, rounded up to whole cycles
  localparam int FDT_N = 9;
  localparam int FDT_MIN_NS = 91_200;
  localparam int FDT_MIN_CYC = (FDT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [11:0] FDT_LAST = 12'(FDT_MIN_CYC - 1);

  // reader timeout, rounded down
  localparam int TIMEOUT_US = 5_000;
  localparam int TIMEOUT_CYC = TIMEOUT_US * 1000 / CLK_PERIOD_NS;

  // kind of reply frame
  typedef enum logic [1:0] {
    RSP_ACK = 2'h0,
    RSP_NAK = 2'h1,
    RSP_DATA = 2'h2,
    RSP_MAC = 2'h3
  } rsp_kind_e;

endpackage

/* File: counter_link_if.sv */
// byte link between the reader end and the card end
// assumes both ends run on the same clock; CRC and CMAC engines sit outside
`timescale 1ns/1ps
interface counter_link_if;
  logic req_valid;
  logic [7:0] req_byte;
  logic req_last;
  logic rsp_valid;
  logic [7:0] rsp_byte;
  logic rsp_last;
  counter_cmd_pkg::rsp_kind_e rsp_kind;
  logic rsp_mac;

  modport card (
    input req_valid, req_byte, req_last,
    output rsp_valid, rsp_byte, rsp_last, rsp_kind, rsp_mac
  );
  modport reader (
    output req_valid, req_byte, req_last,
    input rsp_valid, rsp_byte, rsp_last, rsp_kind, rsp_mac
  );
endinterface

/* File: counter_card.sv */
// card end: decodes counter read and increment frames and replies
// assumes CRC/CMAC checking is done outside and reported on CHECK_OK
`timescale 1ns/1ps
module counter_card (
  input wire logic CLK,
  input wire logic RST_N,
  counter_link_if.card LINK,
  input wire logic SEC_MSG_ENABLE,
  input wire logic AUTHENTICATED,
  input wire logic PROTECT_CNT2,
  input wire logic CHECK_OK,
  output logic OP_DONE,
  output logic OP_OK
);

  localparam int CNT_NUM = counter_cmd_pkg::CNT_NUM;
  typedef counter_cmd_pkg::rsp_kind_e rsp_kind_local_t;

  typedef enum logic [3:0] {
    S_RX = 4'b0001,
    S_EXEC = 4'b0010,
    S_WAIT = 4'b0100,
    S_TX = 4'b1000
  } card_state_e;

  // sequencing state
  card_state_e state;

  // fields captured from the frame being received
  logic [4:0] idx;
  logic [7:0] opcode;
  logic [7:0] cnt_num;
  logic [23:0] arg;
  logic len_ok;
  logic chk_ok;

  // frame delay count and reply byte position
  logic [11:0] wait_cnt;
  logic [1:0] tx_idx;
  logic [23:0] rd_val;

  // counter values, indexed by counter number
  logic [23:0] cnt [CNT_NUM];

  // reply decided at execution, held until sent
  rsp_kind_local_t reply_kind;
  logic reply_mac;

  // decode helpers for the frame being closed and the command held
  logic [4:0] exp_len;
  logic is_read;
  logic is_incr;
  logic [24:0] sum;
  logic [23:0] sel_val;
  logic refused;
  logic next_ok;

  assign is_read = (opcode == counter_cmd_pkg::OP_READ);
  assign is_incr = (opcode == counter_cmd_pkg::OP_INCR);
  // [R01] [R04] [R11] [R12] the CMAC adds bytes only with secure messaging on
  assign exp_len = (is_incr ? counter_cmd_pkg::LEN_INCR : counter_cmd_pkg::LEN_READ)
                 + (SEC_MSG_ENABLE ? counter_cmd_pkg::LEN_MAC : 5'h00);
  assign sel_val = (cnt_num <= counter_cmd_pkg::CNT_LAST) ? cnt[cnt_num[1:0]]
                                                           : counter_cmd_pkg::CNT_RESET;
  // [R08] [R09] [R10] carry out of the 24-bit sum means past the final value
  assign sum = {1'b0, sel_val} + {1'b0, arg};

  // refusal conditions shared by both commands
  always_comb begin
    refused = 1'b0;
    if (!len_ok || !chk_ok) begin
      refused = 1'b1; // [R11] [R12] [R15]
    end
    if (cnt_num > counter_cmd_pkg::CNT_LAST) begin
      refused = 1'b1; // [R15]
    end
    if (cnt_num == counter_cmd_pkg::CNT_LAST && PROTECT_CNT2 && !AUTHENTICATED) begin
      refused = 1'b1; // [R03] [R05] [R16]
    end
    next_ok = !refused && (is_read || !sum[counter_cmd_pkg::CNT_W]); // [R08] [R09]
  end

  // frame reception: byte index, opcode, counter number and argument
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      idx <= 5'h00;
      opcode <= 8'h00;
      cnt_num <= 8'h00;
      arg <= counter_cmd_pkg::CNT_RESET;
      len_ok <= 1'b0;
      chk_ok <= 1'b0;
    end else if (state == S_RX && LINK.req_valid) begin
      // the index saturates so that an overlong frame fails the length test
      if (LINK.req_last) begin
        idx <= 5'h00;
        len_ok <= (idx + 5'h01) == exp_len;
        chk_ok <= CHECK_OK;
      end else if (idx != counter_cmd_pkg::IDX_MAX) begin
        idx <= idx + 5'h01;
      end
      if (idx == counter_cmd_pkg::IDX_OP) begin
        opcode <= LINK.req_byte;
      end
      if (idx == counter_cmd_pkg::IDX_CNT) begin
        cnt_num <= LINK.req_byte;
      end
      // [R06] [R07] low byte first; the fourth byte is dropped
      if (idx >= counter_cmd_pkg::IDX_ARG && idx < counter_cmd_pkg::IDX_ARG_TOP) begin
        arg[8 * (idx - counter_cmd_pkg::IDX_ARG) +: 8] <= LINK.req_byte;
      end
    end
  end

  // counter storage, changed only by an accepted increment
  generate
    for (genvar i = 0; i < CNT_NUM; i++) begin : g_cnt
      always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
          cnt[i] <= counter_cmd_pkg::CNT_RESET;
        end else if (state == S_EXEC && is_incr && next_ok && cnt_num == 8'(i)) begin
          cnt[i] <= sum[counter_cmd_pkg::CNT_W-1:0]; // [R09] [R10]
        end
      end
    end
  endgenerate

  // sequencing: decide, hold off for the frame delay, then send the reply
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state <= S_RX;
      wait_cnt <= 12'h000;
      tx_idx <= 2'h0;
      rd_val <= counter_cmd_pkg::CNT_RESET;
      reply_kind <= counter_cmd_pkg::RSP_NAK;
      reply_mac <= 1'b0;
      OP_DONE <= 1'b0;
      OP_OK <= 1'b0;
    end else begin
      OP_DONE <= 1'b0;
      unique case (state)
        S_RX: begin
          // the delay count starts at the edge that takes the last byte
          wait_cnt <= 12'h001;
          if (LINK.req_valid && LINK.req_last) begin
            // a frame of another command gets no answer from this block
            if ((idx == counter_cmd_pkg::IDX_OP) ? (LINK.req_byte == counter_cmd_pkg::OP_READ
                 || LINK.req_byte == counter_cmd_pkg::OP_INCR) : (is_read || is_incr)) begin
              state <= S_EXEC;
            end
          end
        end
        S_EXEC: begin
          wait_cnt <= wait_cnt + 12'h001;
          rd_val <= sel_val;
          OP_DONE <= 1'b1;
          OP_OK <= next_ok;
          reply_mac <= next_ok && SEC_MSG_ENABLE;
          if (!next_ok) begin
            reply_kind <= counter_cmd_pkg::RSP_NAK; // [R02] [R09] [R15] [R16]
          end else if (is_read) begin
            reply_kind <= counter_cmd_pkg::RSP_DATA; // [R02]
          end else if (SEC_MSG_ENABLE) begin
            reply_kind <= counter_cmd_pkg::RSP_MAC; // [R13]
          end else begin
            reply_kind <= counter_cmd_pkg::RSP_ACK;
          end
          state <= S_WAIT;
        end
        S_WAIT: begin
          // the first reply byte goes out one cycle after the count ends
          wait_cnt <= wait_cnt + 12'h001;
          if (wait_cnt == counter_cmd_pkg::FDT_LAST) begin
            tx_idx <= 2'h0;
            state <= S_TX; // [R14]
          end
        end
        S_TX: begin
          // data replies send three bytes, every other kind a single item
          tx_idx <= tx_idx + 2'h1;
          if (reply_kind != counter_cmd_pkg::RSP_DATA
              || tx_idx == counter_cmd_pkg::DATA_BYTES_LAST) begin
            state <= S_RX;
          end
        end
        default: begin
          state <= S_RX;
        end
      endcase
    end
  end

  // reply bytes: value low byte first, or a single ACK, NAK or MAC marker
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      LINK.rsp_valid <= 1'b0;
      LINK.rsp_byte <= 8'h00;
      LINK.rsp_last <= 1'b0;
      LINK.rsp_kind <= counter_cmd_pkg::RSP_NAK;
      LINK.rsp_mac <= 1'b0;
    end else begin
      LINK.rsp_valid <= (state == S_TX);
      LINK.rsp_kind <= reply_kind;
      LINK.rsp_mac <= reply_mac; // [R02] [R13] framer appends CMAC and CRC
      LINK.rsp_byte <= (reply_kind == counter_cmd_pkg::RSP_DATA) ? rd_val[8 * tx_idx +: 8]
                                                                 : 8'h00;
      LINK.rsp_last <= (state == S_TX) && (reply_kind != counter_cmd_pkg::RSP_DATA
                       || tx_idx == counter_cmd_pkg::DATA_BYTES_LAST);
    end
  end

endmodule

/* File: counter_reader.sv */
// reader end: builds counter frames from a user request and awaits the reply
// assumes the user supplies CMAC and CRC bytes computed outside
`timescale 1ns/1ps
module counter_reader #(
  parameter int TIMEOUT_CYC = counter_cmd_pkg::TIMEOUT_CYC
) (
  input wire logic CLK,
  input wire logic RST_N,
  counter_link_if.reader LINK,
  input wire logic START,
  input wire logic INCR,
  input wire logic [7:0] CNT_SEL,
  input wire logic [31:0] AMOUNT,
  input wire logic SEC_MSG_ENABLE,
  input wire logic [63:0] MAC,
  input wire logic [15:0] CRC,
  output logic BUSY,
  output logic DONE,
  output counter_cmd_pkg::rsp_kind_e RESULT,
  output logic [23:0] VALUE,
  output logic TIMED_OUT
);

  typedef enum logic [2:0] {
    H_IDLE = 3'b001,
    H_SEND = 3'b010,
    H_WAIT = 3'b100
  } reader_state_e;

  reader_state_e state;
  logic [4:0] idx;
  logic [4:0] len;
  logic incr;
  logic sm;
  logic [7:0] cnt_sel;
  logic [31:0] amount;
  logic [63:0] mac;
  logic [15:0] crc;
  logic [17:0] to_cnt;
  logic [1:0] rx_idx;
  logic [7:0] cur_byte;
  logic [4:0] mac_base;
  logic [4:0] crc_base;

  // [R01] [R04] [R07] [R11] [R12] byte at position idx of the frame
  assign mac_base = counter_cmd_pkg::IDX_ARG + (incr ? counter_cmd_pkg::LEN_ARG : 5'h00);
  assign crc_base = mac_base + (sm ? counter_cmd_pkg::LEN_MAC : 5'h00);
  always_comb begin
    cur_byte = crc[8 * (idx - crc_base) +: 8];
    if (idx == counter_cmd_pkg::IDX_OP) begin
      cur_byte = incr ? counter_cmd_pkg::OP_INCR : counter_cmd_pkg::OP_READ;
    end else if (idx == counter_cmd_pkg::IDX_CNT) begin
      cur_byte = cnt_sel;
    end else if (idx < mac_base) begin
      cur_byte = amount[8 * (idx - counter_cmd_pkg::IDX_ARG) +: 8];
    end else if (idx < crc_base) begin
      cur_byte = mac[8 * (idx - mac_base) +: 8];
    end
  end

  // request sequencing, reply collection and timeout
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state <= H_IDLE;
      idx <= 5'h00;
      len <= 5'h00;
      incr <= 1'b0;
      sm <= 1'b0;
      cnt_sel <= 8'h00;
      amount <= 32'h0000_0000;
      mac <= 64'h0000_0000_0000_0000;
      crc <= 16'h0000;
      to_cnt <= 18'h0_0000;
      rx_idx <= 2'h0;
      BUSY <= 1'b0;
      DONE <= 1'b0;
      RESULT <= counter_cmd_pkg::RSP_NAK;
      VALUE <= counter_cmd_pkg::CNT_RESET;
      TIMED_OUT <= 1'b0;
      LINK.req_valid <= 1'b0;
      LINK.req_byte <= 8'h00;
      LINK.req_last <= 1'b0;
    end else begin
      DONE <= 1'b0;
      LINK.req_valid <= 1'b0;
      LINK.req_last <= 1'b0;
      unique case (state)
        H_IDLE: begin
          if (START) begin
            incr <= INCR;
            sm <= SEC_MSG_ENABLE;
            cnt_sel <= CNT_SEL;
            amount <= AMOUNT;
            mac <= MAC;
            crc <= CRC;
            len <= (INCR ? counter_cmd_pkg::LEN_INCR : counter_cmd_pkg::LEN_READ)
                 + (SEC_MSG_ENABLE ? counter_cmd_pkg::LEN_MAC : 5'h00);
            idx <= 5'h00;
            BUSY <= 1'b1;
            TIMED_OUT <= 1'b0;
            state <= H_SEND;
          end
        end
        H_SEND: begin
          LINK.req_valid <= 1'b1;
          LINK.req_byte <= cur_byte;
          LINK.req_last <= (idx + 5'h01) == len;
          idx <= idx + 5'h01;
          to_cnt <= 18'h0_0000;
          rx_idx <= 2'h0;
          if ((idx + 5'h01) == len) begin
            state <= H_WAIT;
          end
        end
        H_WAIT: begin
          to_cnt <= to_cnt + 18'h0_0001;
          if (LINK.rsp_valid) begin
            rx_idx <= rx_idx + 2'h1;
            if (LINK.rsp_kind == counter_cmd_pkg::RSP_DATA) begin
              VALUE[8 * rx_idx +: 8] <= LINK.rsp_byte;
            end
            if (LINK.rsp_last) begin
              RESULT <= LINK.rsp_kind;
              DONE <= 1'b1;
              BUSY <= 1'b0;
              state <= H_IDLE;
            end
          end else if (to_cnt == 18'(TIMEOUT_CYC - 1)) begin
            TIMED_OUT <= 1'b1; // [R14]
            DONE <= 1'b1;
            BUSY <= 1'b0;
            state <= H_IDLE;
          end
        end
        default: begin
          state <= H_IDLE;
        end
      endcase
    end
  end

endmodule

/* File: counter_link_properties.sv */
// link checker: timing and framing relations on the card/reader byte link
// assumes one clock for both ends; instantiated beside the link in tb
`timescale 1ns/1ps
module counter_link_properties (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic req_valid,
  input wire logic [7:0] req_byte,
  input wire logic req_last,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_byte,
  input wire logic rsp_last,
  input wire counter_cmd_pkg::rsp_kind_e rsp_kind,
  input wire logic rsp_mac
);
  localparam int FDT = counter_cmd_pkg::FDT_MIN_CYC;
  logic [12:0] gap;
  logic [4:0] nb;
  logic pending;
  default clocking @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  // cycles since the end of the last request frame, saturating
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      gap <= 13'h1fff;
    end else if (req_valid && req_last) begin
      gap <= 13'h0000;
    end else if (gap != 13'h1fff) begin
      gap <= gap + 13'h0001;
    end
  end
  // byte position inside the request frame
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      nb <= 5'h00;
    end else if (req_valid) begin
      nb <= req_last ? 5'h00 : nb + 5'h01;
    end
  end
  // a reply is owed between frame end and reply end
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pending <= 1'b0;
    end else if (req_valid && req_last) begin
      pending <= 1'b1;
    end else if (rsp_valid && rsp_last) begin
      pending <= 1'b0;
    end
  end

  sequence data_tail;
    !rsp_last ##1 (rsp_valid && rsp_kind == counter_cmd_pkg::RSP_DATA && !rsp_last)
      ##1 (rsp_valid && rsp_last);
  endsequence

  a_reply_not_early: assert property (rsp_valid |-> gap >= 13'(FDT))
    else $error("reply byte before minimum frame delay");
  a_reply_start_exact: assert property (rsp_valid && !$past(rsp_valid) |-> gap == 13'(FDT))
    else $error("reply start not at frame delay");
  a_data_three_bytes: assert property (
    rsp_valid && rsp_kind == counter_cmd_pkg::RSP_DATA
    && !$past(rsp_valid) |-> data_tail)
    else $error("data reply not three bytes");
  a_nak_single_item: assert property (
    rsp_valid && rsp_kind == counter_cmd_pkg::RSP_NAK
    |-> rsp_last && rsp_byte == 8'h00 && !rsp_mac)
    else $error("nak reply malformed");
  a_ack_single_item: assert property (
    rsp_valid && rsp_kind == counter_cmd_pkg::RSP_ACK
    |-> rsp_last && !rsp_mac)
    else $error("ack reply malformed");
  a_mac_replaces_ack: assert property (
    rsp_valid && rsp_kind == counter_cmd_pkg::RSP_MAC
    |-> rsp_mac && rsp_last)
    else $error("mac reply without mac flag");
  a_frame_opcode: assert property (
    req_valid && nb == 5'h00
    |-> req_byte == 8'h39 || req_byte == 8'ha5)
    else $error("frame opens with unknown opcode");
  a_frame_length: assert property (
    req_valid && req_last
    |-> nb == 5'h03 || nb == 5'h07 || nb == 5'h0b || nb == 5'h0f)
    else $error("request frame length wrong");
  a_one_frame_only: assert property (req_valid && nb == 5'h00 |-> !pending)
    else $error("request sent while reply owed");
endmodule

/* File: tb.sv */
// testbench: reader and card joined by the link, driven from the reader user side
// assumes the reader timeout is shortened to 3000 cycles
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin num_errors++; \
  $display("MISMATCH %s exp=%0h got=%0h", nm, e, g); end end
module tb;
  logic clk, rst_n, start, inc, card_sm, rd_sm, auth, prot, chk_ok;
  logic busy, done, op_done, op_ok, timed_out;
  logic [7:0] cnt_sel;
  logic [31:0] amount;
  logic [23:0] value;
  counter_cmd_pkg::rsp_kind_e result;
  logic [7:0] fr [0:15];
  logic [7:0] rb [0:3];
  int fi, ri, num_errors, checked;
  counter_link_if link ();

  counter_card counter_card_inst (.CLK(clk), .RST_N(rst_n), .LINK(link),
    .SEC_MSG_ENABLE(card_sm), .AUTHENTICATED(auth), .PROTECT_CNT2(prot),
    .CHECK_OK(chk_ok), .OP_DONE(op_done), .OP_OK(op_ok));
  counter_reader #(.TIMEOUT_CYC(3000)) counter_reader_inst (.CLK(clk), .RST_N(rst_n),
    .LINK(link), .START(start), .INCR(inc), .CNT_SEL(cnt_sel), .AMOUNT(amount),
    .SEC_MSG_ENABLE(rd_sm), .MAC(64'h0123_4567_89ab_cdef), .CRC(16'h5a5a), .BUSY(busy),
    .DONE(done), .RESULT(result), .VALUE(value), .TIMED_OUT(timed_out));
  counter_link_properties counter_link_properties_inst (.CLK(clk), .RST_N(rst_n),
    .req_valid(link.req_valid), .req_byte(link.req_byte), .req_last(link.req_last),
    .rsp_valid(link.rsp_valid), .rsp_byte(link.rsp_byte), .rsp_last(link.rsp_last),
    .rsp_kind(link.rsp_kind), .rsp_mac(link.rsp_mac));

  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // capture bytes seen on the wire
  always @(posedge clk) begin
    if (link.req_valid) begin
      fr[fi] <= link.req_byte;
      fi <= link.req_last ? 0 : fi + 1;
    end
    if (link.rsp_valid) begin
      rb[ri] <= link.rsp_byte;
      ri <= link.rsp_last ? 0 : ri + 1;
    end
  end

  task automatic tally_and_finish();
    $display("errors=%0d checks=%0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // one complete transaction through the reader, then its checks
  task automatic xact(input logic i, input logic [7:0] sel, input logic [31:0] amt,
                      input counter_cmd_pkg::rsp_kind_e kind, input logic [23:0] val);
    int n;
    int seen;
    @(negedge clk);
    start = 1'b1;
    inc = i;
    cnt_sel = sel;
    amount = amt;
    @(negedge clk);
    start = 1'b0;
    n = 0;
    seen = 0;
    while (done !== 1'b1 && n < 4000) begin
      @(negedge clk);
      n++;
      if (op_done === 1'b1) seen++;
    end
    if (n >= 4000) begin
      num_errors++;
      tally_and_finish();
    end
    `CHK("result", kind, result)
    `CHK("op_ok", kind != counter_cmd_pkg::RSP_NAK, op_ok)
    `CHK("timed_out", 1'b0, timed_out)
    `CHK("busy", 1'b0, busy)
    `CHK("op_done", 1, seen)
    `CHK("opcode", i ? 8'ha5 : 8'h39, fr[0])
    if (i) `CHK("argument", amt, {fr[5], fr[4], fr[3], fr[2]})
    if (kind == counter_cmd_pkg::RSP_DATA) `CHK("value", val, value)
    if (kind == counter_cmd_pkg::RSP_DATA) `CHK("wire", val, {rb[2], rb[1], rb[0]})
  endtask

  initial begin
    {rst_n, start, inc, card_sm, rd_sm, auth, prot} = '0;
    chk_ok = 1'b1;
    cnt_sel = 8'h00;
    amount = 32'h0000_0000;
    fi = 0;
    ri = 0;
    num_errors = 0;
    checked = 0;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    xact(1'b0, 8'h00, 32'h0, counter_cmd_pkg::RSP_DATA, 24'h00_0000);
    xact(1'b1, 8'h00, 32'hab12_3456, counter_cmd_pkg::RSP_ACK, 24'h0);
    xact(1'b0, 8'h00, 32'h0, counter_cmd_pkg::RSP_DATA, 24'h12_3456);
    xact(1'b1, 8'h00, 32'h0, counter_cmd_pkg::RSP_ACK, 24'h0);
    xact(1'b0, 8'h00, 32'h0, counter_cmd_pkg::RSP_DATA, 24'h12_3456);
    xact(1'b1, 8'h00, 32'h00ed_cbaa, counter_cmd_pkg::RSP_NAK, 24'h0);
    xact(1'b1, 8'h00, 32'h00ed_cba9, counter_cmd_pkg::RSP_ACK, 24'h0);
    xact(1'b1, 8'h00, 32'h1, counter_cmd_pkg::RSP_NAK, 24'h0);
    xact(1'b1, 8'h00, 32'h0, counter_cmd_pkg::RSP_ACK, 24'h0);
    xact(1'b0, 8'h00, 32'h0, counter_cmd_pkg::RSP_DATA, 24'hff_ffff);
    xact(1'b0, 8'h03, 32'h0, counter_cmd_pkg::RSP_NAK, 24'h0);
    xact(1'b1, 8'hff, 32'h1, counter_cmd_pkg::RSP_NAK, 24'h0);
    chk_ok = 1'b0;
    xact(1'b1, 8'h01, 32'h1, counter_cmd_pkg::RSP_NAK, 24'h0);
    chk_ok = 1'b1;
    xact(1'b0, 8'h01, 32'h0, counter_cmd_pkg::RSP_DATA, 24'h00_0000);
    prot = 1'b1;
    xact(1'b0, 8'h02, 32'h0, counter_cmd_pkg::RSP_NAK, 24'h0);
    xact(1'b1, 8'h02, 32'h5, counter_cmd_pkg::RSP_NAK, 24'h0);
    auth = 1'b1;
    xact(1'b1, 8'h02, 32'h5, counter_cmd_pkg::RSP_ACK, 24'h0);
    xact(1'b0, 8'h02, 32'h0, counter_cmd_pkg::RSP_DATA, 24'h00_0005);
    {prot, auth} = 2'b00;
    xact(1'b0, 8'h02, 32'h0, counter_cmd_pkg::RSP_DATA, 24'h00_0005);
    {card_sm, rd_sm} = 2'b11;
    xact(1'b0, 8'h01, 32'h0, counter_cmd_pkg::RSP_DATA, 24'h00_0000);
    xact(1'b1, 8'h01, 32'h7, counter_cmd_pkg::RSP_MAC, 24'h0);
    xact(1'b0, 8'h01, 32'h0, counter_cmd_pkg::RSP_DATA, 24'h00_0007);
    rd_sm = 1'b0;
    xact(1'b0, 8'h01, 32'h0, counter_cmd_pkg::RSP_NAK, 24'h0);
    xact(1'b1, 8'h01, 32'h1, counter_cmd_pkg::RSP_NAK, 24'h0);
    tally_and_finish();
  end
endmodule
